/* File: rtl/telemetry_pkg.sv */
// constants and carrier types for the telemetry readback words
package telemetry_pkg;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
    localparam logic [7:0] CMD_OUTPUT_FEEDBACK_READING = 8'h89;
    localparam logic [7:0] CMD_INPUT_CURRENT_READING = 8'h8C;
    localparam int SAMPLE_MSB = 9;
    localparam int SAMPLE_WIDTH = 10;
    localparam int WORD_WIDTH = 16;
    localparam int WORD_BYTES = 2;
    localparam logic [9:0] SAMPLE_FULL_SCALE = 10'h3FF;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef struct packed {
        logic [9:0] input_supply_pin;
        logic [9:0] output_feedback_pin;
        logic [9:0] input_current_monitor_pin;
    } sample_set_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } read_byte_t;
endpackage : telemetry_pkg

/* File: rtl/telemetry_readback_words.sv */
// read-only telemetry word server behind the management-bus command decoder
`timescale 1ns/1ps

// Overview of operation
// - input supply over 48 in bits 9:0
// - feedback pin voltage in bits 9:0
// - current monitor pin voltage in bits 9:0
// - bits 15:10 unused, read zero
// - exactly two data bytes per supported read command, none for writes or unsupported codes
// - words read-only, writes ignored
// - code spans zero to full scale
module telemetry_readback_words (
    input wire logic clk,
    input wire logic rst,
    input telemetry_pkg::sample_set_t samples,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic byte_ready,
    output telemetry_pkg::read_byte_t read_byte,
    output logic cmd_ack,
    output logic cmd_unsupported
);
    typedef enum {IDLE, SEND_LOW, SEND_HIGH} state_t;

    state_t state;
    state_t next_state;
    logic [15:0] word;
    logic [15:0] next_word;
    telemetry_pkg::read_byte_t next_read_byte;
    logic next_cmd_ack;
    logic next_cmd_unsupported;

    // pack a 10-bit sample, upper bits forced to zero
    function automatic logic [15:0] pack_word(input logic [9:0] s);
        pack_word = {6'h00, s};
    endfunction : pack_word

    function automatic logic is_reading(input logic [7:0] c);
        is_reading = (c == telemetry_pkg::CMD_INPUT_VOLTAGE_READING)
            || (c == telemetry_pkg::CMD_OUTPUT_FEEDBACK_READING)
            || (c == telemetry_pkg::CMD_INPUT_CURRENT_READING);
    endfunction : is_reading

    always_comb
    begin
        next_state = state;
        next_word = word;
        next_read_byte = read_byte;
        next_cmd_ack = 1'b0;
        next_cmd_unsupported = 1'b0;
        case (state)
            IDLE:
            begin
                next_read_byte.valid = 1'b0;
                if (cmd_valid)
                begin
                    next_cmd_ack = 1'b1;
                    // a write never alters the reported sample
                    if (cmd_write || !is_reading(cmd_code))
                    begin
                        next_cmd_unsupported = 1'b1;
                    end
                    else
                    begin
                        // word captured once so both bytes belong together
                        if (cmd_code == telemetry_pkg::CMD_INPUT_VOLTAGE_READING)
                        begin
                            next_word = pack_word(samples.input_supply_pin);
                        end
                        else if (cmd_code == telemetry_pkg::CMD_OUTPUT_FEEDBACK_READING)
                        begin
                            next_word = pack_word(samples.output_feedback_pin);
                        end
                        else
                        begin
                            next_word = pack_word(samples.input_current_monitor_pin);
                        end
                        next_state = SEND_LOW;
                    end
                end
            end
            SEND_LOW:
            begin
                next_read_byte.valid = 1'b1;
                next_read_byte.data = word[7:0];
                if (read_byte.valid && byte_ready)
                begin
                    next_read_byte.data = word[15:8];
                    next_state = SEND_HIGH;
                end
            end
            SEND_HIGH:
            begin
                if (byte_ready)
                begin
                    next_read_byte.valid = 1'b0;
                    next_state = IDLE;
                end
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= IDLE;
            word <= telemetry_pkg::WORD_RESET;
            read_byte <= '{valid: 1'b0, data: telemetry_pkg::BYTE_RESET};
            cmd_ack <= 1'b0;
            cmd_unsupported <= 1'b0;
        end
        else
        begin
            state <= next_state;
            word <= next_word;
            read_byte <= next_read_byte;
            cmd_ack <= next_cmd_ack;
            cmd_unsupported <= next_cmd_unsupported;
        end
    end

    // bytes handed over since the last taken command; feeds the length checks only
    logic [7:0] sent_count;
    logic [7:0] next_sent_count;

    always_comb
    begin
        next_sent_count = sent_count;
        if (state == IDLE && cmd_valid)
        begin
            next_sent_count = telemetry_pkg::BYTE_RESET;
        end
        else if (read_byte.valid && byte_ready)
        begin
            next_sent_count = sent_count + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sent_count <= telemetry_pkg::BYTE_RESET;
        end
        else
        begin
            sent_count <= next_sent_count;
        end
    end

    AST_VIN_WORD: assert property (@(posedge clk) disable iff (rst)
        (state == IDLE && cmd_valid && !cmd_write
            && cmd_code == telemetry_pkg::CMD_INPUT_VOLTAGE_READING)
        |=> word == {6'h00, $past(samples.input_supply_pin)})
        else $error("input voltage word mismatch");
    AST_FB_WORD: assert property (@(posedge clk) disable iff (rst)
        (state == IDLE && cmd_valid && !cmd_write
            && cmd_code == telemetry_pkg::CMD_OUTPUT_FEEDBACK_READING)
        |=> word == {6'h00, $past(samples.output_feedback_pin)})
        else $error("feedback word mismatch");
    AST_INPUT_CURRENT_MONITOR_PIN_WORD: assert property (@(posedge clk) disable iff (rst)
        (state == IDLE && cmd_valid && !cmd_write
            && cmd_code == telemetry_pkg::CMD_INPUT_CURRENT_READING)
        |=> word == {6'h00, $past(samples.input_current_monitor_pin)})
        else $error("current monitor word mismatch");
    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_HIGH && read_byte.valid) |-> read_byte.data[7:2] == 6'h00)
        else $error("unused bits not zero");
    AST_TWO_BYTES: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_HIGH && byte_ready) |=> (state == IDLE && !read_byte.valid))
        else $error("more than two bytes sent");
    AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (rst)
        (state == IDLE && cmd_valid && cmd_write) |=> (cmd_unsupported && state == IDLE))
        else $error("write not refused");
    AST_RANGE: assert property (@(posedge clk) disable iff (rst)
        word[9:0] <= telemetry_pkg::SAMPLE_FULL_SCALE && word[15:10] == 6'h00)
        else $error("word outside sample range");
    AST_LOW_FIRST: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_LOW && read_byte.valid && byte_ready)
        |=> (state == SEND_HIGH && read_byte.data == word[15:8]))
        else $error("byte order wrong");
    AST_LOW_DATA: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_LOW && read_byte.valid) |-> read_byte.data == word[7:0])
        else $error("low byte wrong");

    // a host that never raises ready keeps the block busy; no timeout, by intent
    AST_BYTE_LIMIT: assert property (@(posedge clk) disable iff (rst)
        int'(sent_count) <= telemetry_pkg::WORD_BYTES)
        else $error("more than two bytes for one command");
    AST_BYTE_COMPLETE: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_HIGH && read_byte.valid && byte_ready)
        |=> int'(sent_count) == telemetry_pkg::WORD_BYTES)
        else $error("word ended short of two bytes");
    AST_BUSY_IGNORED: assert property (@(posedge clk) disable iff (rst)
        (state != IDLE) |=> !cmd_ack)
        else $error("command taken during a transfer");
    AST_WORD_HELD: assert property (@(posedge clk) disable iff (rst)
        (state != IDLE) |=> $stable(word))
        else $error("word changed between its two bytes");
    AST_UNSUP_ACKED: assert property (@(posedge clk) disable iff (rst)
        cmd_unsupported |-> cmd_ack)
        else $error("refusal without acknowledge");
    AST_WRITE_KEEPS_WORD: assert property (@(posedge clk) disable iff (rst)
        (state == IDLE && cmd_valid && cmd_write) |=> $stable(word))
        else $error("write altered the reported word");
    AST_READ_STARTS: assert property (@(posedge clk) disable iff (rst)
        (cmd_ack && !cmd_unsupported) |=> (state == SEND_LOW && read_byte.valid))
        else $error("low byte not offered after acknowledge");
    AST_LOW_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_LOW && read_byte.valid && !byte_ready)
        |=> (state == SEND_LOW && $stable(read_byte)))
        else $error("low byte dropped before it was taken");
    AST_HIGH_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state == SEND_HIGH && !byte_ready)
        |=> (state == SEND_HIGH && $stable(read_byte)))
        else $error("high byte dropped before it was taken");

    COV_READ_DONE: cover property (@(posedge clk) disable iff (rst)
        state == SEND_HIGH && byte_ready);
    COV_WRITE: cover property (@(posedge clk) disable iff (rst) cmd_unsupported);
    COV_STALL: cover property (@(posedge clk) disable iff (rst)
        state == SEND_LOW && read_byte.valid && !byte_ready);
    COV_READ_START: cover property (@(posedge clk) disable iff (rst)
        cmd_ack && !cmd_unsupported);
endmodule : telemetry_readback_words

/* File: verification/host_model.sv */
// host-side model that takes telemetry bytes and assembles the word
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic stall,
    input telemetry_pkg::read_byte_t read_byte,
    input wire logic cmd_ack,
    output logic byte_ready,
    output logic [15:0] word,
    output logic [7:0] n_bytes
);
    // a slow host withholds ready; it never writes the words
    assign byte_ready = ~stall;
    initial word = 16'h0000;
    initial n_bytes = 8'h00;
    always @(posedge clk)
    begin
        if (cmd_ack)
            n_bytes <= 8'h00;
        else if (read_byte.valid && byte_ready)
        begin
            word <= {read_byte.data, word[15:8]};
            n_bytes <= n_bytes + 8'h01;
        end
    end
endmodule : host_model

/* File: verification/testbench.sv */
// self-checking bench for the telemetry readback words
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    telemetry_pkg::sample_set_t samples = '0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic cmd_write = 1'b0;
    logic stall = 1'b0;
    logic byte_ready, cmd_ack, cmd_unsupported, unsup_seen;
    logic [15:0] word;
    logic [7:0] n_bytes;
    telemetry_pkg::read_byte_t read_byte;
    logic [7:0] codes [3] = '{8'h88, 8'h89, 8'h8C};
    int fail_count = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    telemetry_readback_words uut (.clk(clk), .rst(rst), .samples(samples),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
        .byte_ready(byte_ready), .read_byte(read_byte), .cmd_ack(cmd_ack),
        .cmd_unsupported(cmd_unsupported));
    host_model host (.clk(clk), .stall(stall), .read_byte(read_byte), .cmd_ack(cmd_ack),
        .byte_ready(byte_ready), .word(word), .n_bytes(n_bytes));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one-cycle request, so it cannot be taken a second time
    task automatic send(input logic [7:0] code, input logic wr);
        int i;
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_write <= wr;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 10 && cmd_ack !== 1'b1; i++)
            @(posedge clk);
        unsup_seen = cmd_unsupported;
        chk("ack", 16'h0001, {15'h0000, cmd_ack});
        repeat (8) @(posedge clk);
    endtask : send
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        samples <= {10'h3FF, 10'h155, 10'h000};
        @(posedge clk);
        for (int k = 0; k < 3; k++)
        begin
            send(codes[k], 1'b0);
            chk("word", {6'h00, samples[29 - 10 * k -: 10]}, word);
            chk("bytes", 16'h0002, {8'h00, n_bytes});
            chk("unsup", 16'h0000, {15'h0000, unsup_seen});
        end
        samples <= {10'h07D, 10'h2AA, 10'h3FF};
        stall <= 1'b1;
        send(8'h8C, 1'b0);
        chk("stalled", 16'h0000, {8'h00, n_bytes});
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        chk("word", 16'h03FF, word);
        chk("bytes", 16'h0002, {8'h00, n_bytes});
        send(8'h89, 1'b1);
        chk("unsup", 16'h0001, {15'h0000, unsup_seen});
        chk("bytes", 16'h0000, {8'h00, n_bytes});
        send(8'h8D, 1'b0);
        chk("unsup", 16'h0001, {15'h0000, unsup_seen});
        send(8'h89, 1'b0);
        chk("word", 16'h02AA, word);
        send(8'h88, 1'b0);
        chk("word", 16'h007D, word);
        print_verdict();
    end
endmodule : testbench
